//--- rtl/board_mode_pkg.sv
// Constants and types shared by the board mode latch and memory decoder
package board_mode_pkg;

	// APB map, byte addresses
	localparam int unsigned APB_ADDR_W = 8;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] EVCNT_OFF = 8'h08;

	// Control register fields
	localparam int unsigned CTRL_LINK_BIT = 0;
	localparam int unsigned CTRL_CAPTURE_BIT = 1;
	localparam logic CTRL_LINK_RST = 1'b1;

	// Status register fields
	localparam int unsigned STAT_FLASH_BIT = 0;
	localparam int unsigned STAT_RUN_BIT = 1;
	localparam int unsigned STAT_SW_BIT = 2;
	localparam int unsigned STAT_PEND_BIT = 3;

	// Event counter
	localparam int unsigned EVCNT_W = 8;
	localparam logic [7:0] EVCNT_RST = 8'h00;

	// Memory geometry: reachable space per device and fitted size, in K
	localparam int unsigned SPACE_KB = 64;
	localparam int unsigned FITTED_KB = 128;
	localparam int unsigned BANK_W = 3;
	localparam logic [2:0] BANK_LOW = 3'h0;

	// Operating modes
	typedef enum logic [0:0] {
		MODE_RUN = 1'b0,
		MODE_FLASH_LOAD = 1'b1
	} mode_e;

	localparam mode_e MODE_RST = MODE_FLASH_LOAD;

endpackage

//--- rtl/mode_capture.sv
// Mode latch: samples the slide switch at each reset event
`timescale 1ns/1ps
module mode_capture
	import board_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode_switch,
	input wire logic board_rst_n,
	input wire logic soft_capture,
	output logic capture_now,
	output mode_e mode
);

	logic boot_ff;
	logic rst_prev_ff;
	mode_e mode_ff;

	// First cycle after release counts as a power-up reset event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
		end
	end

	// Previous board reset level for press detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_prev_ff <= 1'b1;
		end else begin
			rst_prev_ff <= board_rst_n;
		end
	end

	// Reset press, power-up or software request
	assign capture_now = boot_ff | (rst_prev_ff & ~board_rst_n) | soft_capture;

	// Switch copied into mode only on a capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= MODE_RST;
		end else if (capture_now) begin
			mode_ff <= mode_switch ? MODE_FLASH_LOAD : MODE_RUN;
		end
	end

	assign mode = mode_ff;

endmodule

//--- rtl/mem_decode.sv
// Strobe steering to flash and RAM chip selects
`timescale 1ns/1ps
module mem_decode
	import board_mode_pkg::*;
(
	input mode_e mode,
	input wire logic cpu_psen_n,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	output logic flash_sel_n,
	output logic flash_rd_n,
	output logic flash_wr_n,
	output logic ram_sel_n,
	output logic ram_rd_n,
	output logic ram_wr_n,
	output logic [BANK_W-1:0] bank_addr
);

	// Only the low 64K bank of each device is used
	assign bank_addr = BANK_LOW;

	// Per-mode routing of fetch and data strobes
	always_comb begin
		flash_sel_n = 1'b1;
		flash_rd_n = 1'b1;
		flash_wr_n = 1'b1;
		ram_sel_n = 1'b1;
		ram_rd_n = 1'b1;
		ram_wr_n = 1'b1;
		unique case (mode)
			MODE_FLASH_LOAD: begin
				flash_sel_n = cpu_rd_n & cpu_wr_n;
				flash_rd_n = cpu_rd_n;
				flash_wr_n = cpu_wr_n;
			end
			MODE_RUN: begin
				flash_sel_n = cpu_psen_n;
				flash_rd_n = cpu_psen_n;
				ram_sel_n = cpu_rd_n & cpu_wr_n;
				ram_rd_n = cpu_rd_n;
				ram_wr_n = cpu_wr_n;
			end
		endcase
	end

endmodule

//--- rtl/board_mode_memory_decoder.sv
// Board mode latch, status lamps, memory decoder and APB registers
`timescale 1ns/1ps
module board_mode_memory_decoder
	import board_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_switch,
	input wire logic board_rst_n,
	input wire logic cpu_psen_n,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	output logic flash_sel_n,
	output logic flash_rd_n,
	output logic flash_wr_n,
	output logic ram_sel_n,
	output logic ram_rd_n,
	output logic ram_wr_n,
	output logic [BANK_W-1:0] bank_addr,
	output logic lamp_red,
	output logic lamp_green,
	output logic mode_indicator_out,
	output logic code_ea_n
);

	// APB phase decode
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic addr_hit;

	// Control and status state
	logic link_ff;
	logic capture_req_ff;
	logic [EVCNT_W-1:0] evcnt_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;

	// Mode latch outputs
	logic capture_now;
	mode_e mode;

	// True when an address names one of the three registers
	function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] a);
		is_mapped = (a == CTRL_OFF) || (a == STATUS_OFF) ||
			(a == EVCNT_OFF);
	endfunction

	// Phase qualifiers
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign addr_hit = is_mapped(paddr);
	assign wr_access = access_phase & pwrite & addr_hit;

	// Zero wait states; unmapped addresses error out
	assign pready = access_phase;
	assign pslverr = access_phase & ~addr_hit;
	assign prdata = prdata_ff;

	// Internal code unmap link, byte lane 0 of control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_ff <= CTRL_LINK_RST;
		end else if (wr_access && paddr == CTRL_OFF && pstrb[0]) begin
			link_ff <= pwdata[CTRL_LINK_BIT];
		end
	end

	// Software capture request, one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_req_ff <= 1'b0;
		end else begin
			capture_req_ff <= wr_access && paddr == CTRL_OFF &&
				pstrb[0] && pwdata[CTRL_CAPTURE_BIT];
		end
	end

	// Count of mode capture events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evcnt_ff <= EVCNT_RST;
		end else if (capture_now) begin
			evcnt_ff <= evcnt_ff + EVCNT_W'(1);
		end
	end

	// Read mux for the next read data word
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (paddr == CTRL_OFF) begin
			nxt_rdata[CTRL_LINK_BIT] = link_ff;
		end else if (paddr == STATUS_OFF) begin
			nxt_rdata[STAT_FLASH_BIT] = (mode == MODE_FLASH_LOAD);
			nxt_rdata[STAT_RUN_BIT] = (mode == MODE_RUN);
			nxt_rdata[STAT_SW_BIT] = mode_switch;
			nxt_rdata[STAT_PEND_BIT] = mode_switch ^
				(mode == MODE_FLASH_LOAD);
		end else if (paddr == EVCNT_OFF) begin
			nxt_rdata[EVCNT_W-1:0] = evcnt_ff;
		end
	end

	// Read data loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata_ff <= nxt_rdata;
		end
	end

	// Mode latch
	mode_capture u_mode_capture (
		.pclk(pclk),
		.presetn(presetn),
		.mode_switch(mode_switch),
		.board_rst_n(board_rst_n),
		.soft_capture(capture_req_ff),
		.capture_now(capture_now),
		.mode(mode)
	);

	// Chip select steering
	mem_decode u_mem_decode (
		.mode(mode),
		.cpu_psen_n(cpu_psen_n),
		.cpu_rd_n(cpu_rd_n),
		.cpu_wr_n(cpu_wr_n),
		.flash_sel_n(flash_sel_n),
		.flash_rd_n(flash_rd_n),
		.flash_wr_n(flash_wr_n),
		.ram_sel_n(ram_sel_n),
		.ram_rd_n(ram_rd_n),
		.ram_wr_n(ram_wr_n),
		.bank_addr(bank_addr)
	);

	// Lamps and mode output straight from the mode register
	assign lamp_red = (mode == MODE_FLASH_LOAD);
	assign lamp_green = (mode == MODE_RUN);
	assign mode_indicator_out = (mode == MODE_FLASH_LOAD);

	// Linked: mode output picks internal or external fetch
	assign code_ea_n = link_ff ? mode_indicator_out : 1'b1;

	// Checks on the block's outputs and internal signals
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Two mutually exclusive modes, one lamp each
	one_lamp_a: assert property (lamp_red ^ lamp_green)
		else $error("lamps not exclusive");

	// Reset press loads the switch into the mode
	reset_load_a: assert property (
		$past(board_rst_n) && !board_rst_n |=>
			mode_indicator_out == $past(mode_switch))
		else $error("mode not loaded at reset press");

	// No capture, no mode change
	mode_hold_a: assert property (
		!capture_now |=> $stable(mode_indicator_out))
		else $error("mode changed without reset event");

	// Switch moved with reset held high leaves the mode
	switch_ignore_a: assert property (
		board_rst_n && !capture_now && !capture_req_ff ##1
		$changed(mode_switch) && board_rst_n && !capture_req_ff
		|-> $stable(mode_indicator_out))
		else $error("switch leaked into mode");

	// Red lamp tracks flash-load mode
	red_lamp_a: assert property (
		lamp_red == (mode == MODE_FLASH_LOAD))
		else $error("red lamp wrong");

	// Green lamp tracks run mode
	green_lamp_a: assert property (
		lamp_green == (mode == MODE_RUN))
		else $error("green lamp wrong");

	// Flash-load: flash select follows data strobes
	load_flash_a: assert property (
		lamp_red |-> flash_sel_n == (cpu_rd_n & cpu_wr_n) &&
			flash_rd_n == cpu_rd_n && flash_wr_n == cpu_wr_n)
		else $error("flash not in data space");

	// Flash-load: RAM fully idle
	ram_off_a: assert property (
		lamp_red |-> ram_sel_n && ram_rd_n && ram_wr_n)
		else $error("ram reachable in load mode");

	// Run: fetch to flash, data to RAM
	run_map_a: assert property (
		lamp_green |-> flash_sel_n == cpu_psen_n &&
			flash_rd_n == cpu_psen_n && flash_wr_n &&
			ram_sel_n == (cpu_rd_n & cpu_wr_n))
		else $error("run map wrong");

	// Link steers code fetch select
	ea_link_a: assert property (
		code_ea_n == (link_ff ? lamp_red : 1'b1))
		else $error("code fetch select wrong");

	// Bank lines stay at zero
	bank_low_a: assert property (
		bank_addr == BANK_LOW)
		else $error("bank lines driven");

	// Never both devices selected
	no_overlap_a: assert property (
		!(!flash_sel_n && !ram_sel_n))
		else $error("code and data overlap");

	// Mode output agrees with red lamp
	mode_out_a: assert property (
		mode_indicator_out == lamp_red && mode_indicator_out != lamp_green)
		else $error("mode output wrong");

	// RAM strobes pass through in run mode
	ram_strobe_a: assert property (
		lamp_green |-> ram_rd_n == cpu_rd_n && ram_wr_n == cpu_wr_n)
		else $error("ram strobes wrong");

	// Software capture changes mode two cycles after write
	soft_capture_a: assert property (
		wr_access && paddr == CTRL_OFF && pstrb[0] &&
		pwdata[CTRL_CAPTURE_BIT] ##1 $stable(mode_switch)
		|=> mode_indicator_out == $past(mode_switch))
		else $error("software capture missed");

	// Zero wait states: ready in the first access cycle
	ready_now_a: assert property (
		psel && penable |-> pready)
		else $error("ready late");

	// Error only for addresses outside the three registers
	err_map_a: assert property (
		psel && penable |-> pslverr == (paddr != CTRL_OFF &&
			paddr != STATUS_OFF && paddr != EVCNT_OFF))
		else $error("error response wrong");

	// Read data stands between read setups
	rdata_hold_a: assert property (
		!(setup_phase && !pwrite) |=> $stable(prdata))
		else $error("read data moved");

	// Control read shows the link, capture bit reads zero
	ctrl_read_a: assert property (
		setup_phase && !pwrite && paddr == CTRL_OFF |=>
			prdata == {31'h0000_0000, $past(link_ff)})
		else $error("control read wrong");

	// Status read shows mode and switch level
	status_read_a: assert property (
		setup_phase && !pwrite && paddr == STATUS_OFF |=>
			prdata[STAT_FLASH_BIT] == $past(lamp_red) &&
			prdata[STAT_RUN_BIT] == $past(lamp_green) &&
			prdata[STAT_SW_BIT] == $past(mode_switch))
		else $error("status read wrong");

	// Pending flag when switch and mode disagree
	pend_read_a: assert property (
		setup_phase && !pwrite && paddr == STATUS_OFF |=>
			prdata[STAT_PEND_BIT] ==
				($past(mode_switch) != $past(lamp_red)) &&
			prdata[31:STAT_PEND_BIT+1] == '0)
		else $error("pending flag wrong");

	// Event count read back, upper bits zero
	evcnt_read_a: assert property (
		setup_phase && !pwrite && paddr == EVCNT_OFF |=>
			prdata == 32'($past(evcnt_ff)))
		else $error("event count read wrong");

	// Unmapped reads return zero
	hole_read_a: assert property (
		setup_phase && !pwrite && paddr != CTRL_OFF &&
		paddr != STATUS_OFF && paddr != EVCNT_OFF |=>
			prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Control write with lane 0 sets the link
	link_write_a: assert property (
		psel && penable && pwrite && paddr == CTRL_OFF && pstrb[0] |=>
			link_ff == $past(pwdata[CTRL_LINK_BIT]))
		else $error("link write lost");

	// Link holds without a lane 0 control write
	link_keep_a: assert property (
		!(psel && penable && pwrite && paddr == CTRL_OFF && pstrb[0])
			|=> $stable(link_ff))
		else $error("link changed alone");

	// Software capture request lasts one cycle
	capture_pulse_a: assert property (
		capture_req_ff |=> !capture_req_ff)
		else $error("capture request stuck");

	// No capture request without a write of the capture bit
	no_soft_a: assert property (
		!(psel && penable && pwrite && paddr == CTRL_OFF && pstrb[0] &&
			pwdata[CTRL_CAPTURE_BIT]) |=> !capture_req_ff)
		else $error("spurious capture request");

	// Each capture adds one to the event count
	evcnt_step_a: assert property (
		presetn && capture_now |=>
			evcnt_ff == EVCNT_W'($past(evcnt_ff) + 1'b1))
		else $error("event count missed");

	// Count holds between captures
	evcnt_hold_a: assert property (
		!capture_now |=> $stable(evcnt_ff))
		else $error("event count moved");

	// Reset press is a capture event
	press_cap_a: assert property (
		$past(board_rst_n) && !board_rst_n |-> capture_now)
		else $error("reset press not seen");

	// Flash-load: fetches stay internal, no external select
	load_fetch_a: assert property (
		lamp_red && !cpu_psen_n && cpu_rd_n && cpu_wr_n |->
			flash_sel_n && ram_sel_n)
		else $error("fetch left the chip in load mode");

	// Run: a fetch selects and reads flash, never writes it
	run_fetch_a: assert property (
		lamp_green && !cpu_psen_n |->
			!flash_sel_n && !flash_rd_n && flash_wr_n)
		else $error("run fetch not on flash");

	// Run: a data strobe selects RAM, not flash
	run_data_a: assert property (
		lamp_green && cpu_psen_n && !(cpu_rd_n && cpu_wr_n) |->
			!ram_sel_n && flash_sel_n)
		else $error("run data not on RAM");

	// Run with link fitted: fetch from external flash
	link_run_a: assert property (
		link_ff && lamp_green |-> !code_ea_n)
		else $error("external fetch not selected");

	// Main scenarios
	enter_run_c: cover property (lamp_red ##1 lamp_green);
	soft_load_c: cover property (capture_req_ff ##2 lamp_red);
	enter_load_c: cover property (lamp_green ##1 lamp_red);
	run_data_c: cover property (lamp_green && !ram_sel_n && !ram_wr_n);
	load_prog_c: cover property (lamp_red && !flash_wr_n);

endmodule

//--- sim/cpu_strobe_model.sv
// Model of the CPU strobes: one active-low strobe per request kind
`timescale 1ns/1ps
module cpu_strobe_model (
	input wire logic pclk,
	input wire logic [1:0] kind,
	output logic psen_n,
	output logic rd_n,
	output logic wr_n
);
	// Kind 1 fetch, 2 read, 3 write; never two strobes at once
	always_ff @(posedge pclk) begin
		psen_n <= (kind != 2'h1);
		rd_n <= (kind != 2'h2);
		wr_n <= (kind != 2'h3);
	end
endmodule

//--- sim/board_mode_memory_decoder_bench.sv
// Self-checking bench for the mode latch, lamps, decoder and registers
`timescale 1ns/1ps
module board_mode_memory_decoder_bench;
	import board_mode_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [APB_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, mode_switch = 1, board_rst_n = 1;
	logic cpu_psen_n, cpu_rd_n, cpu_wr_n, flash_sel_n, flash_rd_n;
	logic flash_wr_n, ram_sel_n, ram_rd_n, ram_wr_n, lamp_red, lamp_green;
	logic mode_indicator_out, code_ea_n, err, exp_mode = 1, link = 1;
	logic [BANK_W-1:0] bank_addr;
	logic [1:0] kind = 2'h0;
	logic [7:0] cnt0;
	int num_errors = 0, n_checks = 0;

	// Clock, 4 ns period
	always #2 pclk = ~pclk;

	cpu_strobe_model u_cpu_strobe_model (.pclk, .kind, .psen_n(cpu_psen_n),
		.rd_n(cpu_rd_n), .wr_n(cpu_wr_n));

	board_mode_memory_decoder u_board_mode_memory_decoder (.pclk, .presetn,
		.paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .mode_switch, .board_rst_n, .cpu_psen_n, .cpu_rd_n,
		.cpu_wr_n, .flash_sel_n, .flash_rd_n, .flash_wr_n, .ram_sel_n,
		.ram_rd_n, .ram_wr_n, .bank_addr, .lamp_red, .lamp_green,
		.mode_indicator_out, .code_ea_n);

	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Expected selects {flash sel,rd,wr, ram sel,rd,wr} for a strobe kind
	function automatic logic [5:0] exp_dec(logic m, logic [1:0] k);
		logic p, r, w;
		p = (k != 2'h1);
		r = (k != 2'h2);
		w = (k != 2'h3);
		if (m)
			return {r & w, r, w, 3'b111};
		return {p, p, 1'b1, r & w, r, w};
	endfunction

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; waits for pready, only the watchdog ends a wait
	task automatic apb(logic wr, logic [APB_ADDR_W-1:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic check_mode();
		@(negedge pclk);
		check("red", exp_mode, lamp_red);
		check("green", !exp_mode, lamp_green);
		check("mode_out", exp_mode, mode_indicator_out);
		check("code_ea", link ? exp_mode : 1'b1, code_ea_n);
	endtask

	// Press the board reset with the switch at sw, hold, release
	task automatic press(logic sw);
		@(posedge pclk);
		mode_switch <= sw;
		board_rst_n <= 0;
		repeat (3) @(posedge pclk);
		board_rst_n <= 1;
		repeat (2) @(posedge pclk);
		exp_mode = sw;
		check_mode();
	endtask

	task automatic strobe(logic [1:0] k);
		@(posedge pclk);
		kind <= k;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("decode", exp_dec(exp_mode, k), {flash_sel_n, flash_rd_n,
			flash_wr_n, ram_sel_n, ram_rd_n, ram_wr_n});
		check("bank", '0, bank_addr);
	endtask

	// Watchdog
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h4aed));
		repeat (16) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		check_mode();
		for (int k = 0; k < 4; k++)
			strobe(k[1:0]);
		// Switch moved alone leaves the mode
		@(posedge pclk);
		mode_switch <= 0;
		repeat (5) @(posedge pclk);
		check_mode();
		apb(0, EVCNT_OFF, '0);
		cnt0 = rd[7:0];
		check("evcnt_boot", 32'h0000_0001, rd);
		press(0);
		for (int k = 0; k < 4; k++)
			strobe(k[1:0]);
		apb(0, STATUS_OFF, '0);
		check("status", {28'h0, exp_mode != mode_switch, mode_switch,
			!exp_mode, exp_mode}, rd);
		apb(0, EVCNT_OFF, '0);
		check("evcnt", cnt0 + 8'h1, rd[7:0]);
		// Jumper link open: internal code fetch
		apb(1, CTRL_OFF, '0);
		link = 0;
		check_mode();
		// Soft capture with switch in flash-load position
		@(posedge pclk);
		mode_switch <= 1;
		apb(1, CTRL_OFF, 32'h3);
		link = 1;
		exp_mode = 1;
		repeat (2) @(posedge pclk);
		check_mode();
		// Write with lane 0 off is ignored
		pstrb <= 4'h0;
		apb(1, CTRL_OFF, '0);
		pstrb <= 4'hf;
		apb(0, CTRL_OFF, '0);
		check("ctrl", 32'h1, rd);
		apb(0, 8'h40, '0);
		check("unmapped_err", 1'b1, err);
		check("unmapped_data", '0, rd);
		apb(1, STATUS_OFF, '1);
		check("ro_err", 1'b0, err);
		// Random presses, switch moves and strobes
		repeat (40) begin
			if ($urandom % 3 == 0)
				press(1'($urandom % 2));
			else begin
				@(posedge pclk);
				mode_switch <= 1'($urandom % 2);
				repeat (2) @(posedge pclk);
				check_mode();
			end
			strobe(2'($urandom % 4));
		end
		// Second power reset in mid-run
		@(posedge pclk);
		mode_switch <= 0;
		presetn <= 0;
		exp_mode = 1;
		repeat (2) @(posedge pclk);
		check_mode();
		@(posedge pclk);
		presetn <= 1;
		exp_mode = 0;
		repeat (2) @(posedge pclk);
		check_mode();
		strobe(2'h3);
		complete_run();
	end
endmodule
